//--- plear_top.sv
// Loopback control, receive error substitution and strap-latched address
// and serial-mode registers. Management access is a simple register port;
// the receive path carries at most one nibble per clock with valid/ready.
module plear_top #(
  parameter int DEAD_CYC = plear_pkg::DEAD_CYCLES,
  parameter int TMO_CYC  = plear_pkg::TMO_CYCLES
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // Straps and status inputs
  input  wire logic [4:0]            station_address_straps,
  input  wire logic                  ten_mb_serial_strap,
  input  wire logic                  speed_is_10,
  input  wire logic                  link_connected,
  input  wire logic                  activity_led_source_select,
  input  wire logic                  tx_activity,
  // Management register port
  input  wire logic [4:0]            mgmt_addr,
  input  wire logic                  mgmt_wr,
  input  wire logic                  mgmt_rd,
  input  wire logic [15:0]           mgmt_wdata,
  output logic      [15:0]           mgmt_rdata,
  output logic                       mgmt_rvalid,
  // Receive symbols in
  input  wire logic                  rx_in_valid,
  output logic                       rx_in_ready,
  input  wire logic [3:0]            rx_in_nib,
  input  wire plear_pkg::plear_sym_t rx_in_sym,
  // Receive nibbles out to MAC
  output logic                       rx_out_valid,
  input  wire logic                  rx_out_ready,
  output plear_pkg::plear_rx_t       rx_out,
  // Loop and mode outputs
  output logic                       remote_loop_tx_valid,
  output logic      [3:0]            remote_loop_tx_nib,
  output logic                       xcvr_loop_en,
  output logic                       isolate_set,
  output logic                       serial_mode_active,
  output logic                       activity_led_pin
);

  // ***********************************************************
  // Registers
  // ***********************************************************
  logic [15:0] loop_err_q;
  logic [4:0]  addr_q;
  logic        serial_q;
  logic        connect_flag_q;
  logic        strap_done_q;
  logic [1:0]  loop_select;
  assign loop_select = loop_err_q[plear_pkg::LOOP_SEL_LSB +: 2];

  // Loop/error control, writable bits only; reserved bits keep reset value
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      loop_err_q <= plear_pkg::LOOP_ERR_RST;
    end else if (mgmt_wr && mgmt_addr == plear_pkg::IDX_LOOP_ERR) begin
      loop_err_q <= (loop_err_q & ~plear_pkg::LOOP_ERR_WMASK)
                  | (mgmt_wdata & plear_pkg::LOOP_ERR_WMASK);
    end
  end

  // Straps captured on the first edge after release, then writable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_done_q <= 1'b0;
      addr_q       <= 5'h00;
      serial_q     <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      addr_q       <= station_address_straps;
      serial_q     <= ten_mb_serial_strap;
    end else if (mgmt_wr) begin
      if (mgmt_addr == plear_pkg::IDX_ADDR_SPEED) begin
        addr_q <= mgmt_wdata[4:0];
      end else if (mgmt_addr == plear_pkg::IDX_TEN_STATUS) begin
        serial_q <= mgmt_wdata[plear_pkg::SERIAL_BIT];
      end
    end
  end

  // Connect flag follows the disconnect function result
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      connect_flag_q <= 1'b0;
    end else begin
      connect_flag_q <= link_connected;
    end
  end

  // Read mux; reserved bits read as zero except loop/error bit 15, which keeps its reset value of one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mgmt_rdata  <= 16'h0000;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= mgmt_rd;
      if (!mgmt_rd) begin
        mgmt_rdata <= 16'h0000;
      end else if (mgmt_addr == plear_pkg::IDX_LOOP_ERR) begin
        mgmt_rdata <= loop_err_q;
      end else if (mgmt_addr == plear_pkg::IDX_ADDR_SPEED) begin
        mgmt_rdata <= {9'h000, speed_is_10, connect_flag_q, addr_q};
      end else if (mgmt_addr == plear_pkg::IDX_TEN_STATUS) begin
        mgmt_rdata <= {6'h00, serial_q, 9'h000};
      end else begin
        mgmt_rdata <= 16'h0000;
      end
    end
  end

  // ***********************************************************
  // Mode outputs
  // ***********************************************************
  // Mode levels, each registered one cycle after its inputs.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      xcvr_loop_en       <= 1'b0;
      isolate_set        <= 1'b0;
      serial_mode_active <= 1'b0;
      activity_led_pin   <= 1'b0;
    end else begin
      xcvr_loop_en       <= loop_select == plear_pkg::LOOP_XCVR;
      isolate_set        <= strap_done_q && addr_q == 5'h00;
      serial_mode_active <= serial_q && speed_is_10;
      activity_led_pin   <= activity_led_source_select ?
                            connect_flag_q : tx_activity;
    end
  end

  // ***********************************************************
  // Receive error classification
  // ***********************************************************
  logic [31:0] dead_cnt_q;
  logic [31:0] tmo_cnt_q;
  logic        in_frame_q;
  logic        idle_seen_q;
  logic        early_end;
  logic        tmo_hit;
  logic        dead;
  logic        take;

  // Dead from the very cycle the loop is entered, not one cycle later
  assign dead = dead_cnt_q != 32'h0 ||
                (loop_select == plear_pkg::LOOP_XCVR && !xcvr_loop_en);
  // Two consecutive idles inside a frame before the delimiter
  assign early_end = in_frame_q && idle_seen_q && rx_in_sym.idle;
  assign tmo_hit = in_frame_q && tmo_cnt_q >= 32'(TMO_CYC);

  // Dead-time counter reloads on entering transceiver loop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dead_cnt_q <= 32'h0;
    end else if (loop_select == plear_pkg::LOOP_XCVR && !xcvr_loop_en) begin
      dead_cnt_q <= 32'(DEAD_CYC);
    end else if (dead) begin
      dead_cnt_q <= dead_cnt_q - 32'h1;
    end
  end

  // Frame tracking; the timeout counts clocks so a stalled line still trips
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_frame_q  <= 1'b0;
      idle_seen_q <= 1'b0;
      tmo_cnt_q   <= 32'h0;
    end else begin
      if (take) begin
        if (rx_in_sym.frame_start) begin
          in_frame_q <= 1'b1;
        end else if (rx_in_sym.end_delim || early_end || tmo_hit) begin
          in_frame_q <= 1'b0;
        end
        idle_seen_q <= rx_in_sym.idle && in_frame_q;
      end
      if (take && rx_in_sym.frame_start) begin
        tmo_cnt_q <= 32'h0;
      end else if (in_frame_q && !tmo_hit) begin
        tmo_cnt_q <= tmo_cnt_q + 32'h1;
      end
    end
  end

  // Substitution priority: link, timeout, early end, code error
  function automatic plear_pkg::plear_rx_t subst(
    input logic [15:0] ctl, input logic [3:0] nib,
    input plear_pkg::plear_sym_t s, input logic ee, input logic th);
    subst = '{nib: nib, err: 1'b0};
    if (s.link_err && ctl[plear_pkg::LINK_EN_BIT]) begin
      subst = '{nib: plear_pkg::LINK_ERR_CODE, err: 1'b1};
    end else if (th && ctl[plear_pkg::TMO_EN_BIT]) begin
      subst = '{nib: plear_pkg::TMO_ERR_CODE, err: 1'b1};
    end else if (ee) begin
      subst = '{nib: ctl[plear_pkg::EARLY_SEL_BIT] ?
                plear_pkg::EARLY_ERR_ALT : plear_pkg::GENERIC_ERR,
                err: 1'b1};
    end else if (s.code_err) begin
      subst = '{nib: ctl[plear_pkg::CODE_SEL_BIT] ?
                plear_pkg::CODE_ERR_ALT : plear_pkg::GENERIC_ERR,
                err: 1'b1};
    end
  endfunction : subst

  // ***********************************************************
  // Two-entry output buffer
  // ***********************************************************
  plear_pkg::plear_rx_t buf_q [2];
  logic [1:0] cnt_q, cnt_d;
  logic       wr_ptr_q;
  logic       rd_ptr_q;
  logic       pop;

  assign cnt_d = cnt_q + {1'b0, take && !dead} - {1'b0, pop};
  assign take = rx_in_valid && rx_in_ready;
  assign pop  = rx_out_valid && rx_out_ready;

  // Dead-time words are dropped rather than queued.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'h0;
      rx_in_ready <= 1'b0;
    end else begin
      if (take && !dead) begin
        buf_q[wr_ptr_q] <= subst(loop_err_q, rx_in_nib, rx_in_sym,
                                 early_end, tmo_hit);
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      cnt_q <= cnt_d;
      rx_in_ready <= cnt_d != 2'h2; // Registered, so no path from input
    end
  end

  // Registered output stage tracks buffer head
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_out_valid <= 1'b0;
      rx_out       <= '0;
    end else if (!rx_out_valid || rx_out_ready) begin
      rx_out_valid <= cnt_q > {1'b0, pop} ;
      rx_out       <= buf_q[rd_ptr_q ^ pop];
    end
  end

  // Remote loop copies accepted line nibbles to transmit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      remote_loop_tx_valid <= 1'b0;
      remote_loop_tx_nib   <= 4'h0;
    end else begin
      remote_loop_tx_valid <= take && loop_select == plear_pkg::LOOP_REMOTE;
      remote_loop_tx_nib   <= rx_in_nib;
    end
  end

  // ***********************************************************
  // Assertions
  // ***********************************************************
  property p_code_err;
    @(posedge clk) disable iff (!arst_n)
      take && !dead && rx_in_sym.code_err && !rx_in_sym.link_err &&
      !early_end && !tmo_hit |=> buf_q[$past(wr_ptr_q)].err;
  endproperty
  a_code_err: assert property (p_code_err)
    else $error("code error not flagged");
  property p_isolate;
    @(posedge clk) disable iff (!arst_n)
      strap_done_q && addr_q == 5'h00 |=> isolate_set;
  endproperty
  a_isolate: assert property (p_isolate)
    else $error("isolate not set for zero address");
  property p_led;
    @(posedge clk) disable iff (!arst_n)
      activity_led_source_select |=> activity_led_pin == $past(connect_flag_q);
  endproperty
  a_led: assert property (p_led)
    else $error("led not following connect flag");
  property p_serial;
    @(posedge clk) disable iff (!arst_n)
      !speed_is_10 |=> !serial_mode_active;
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial mode at high rate");
  property p_remote;
    @(posedge clk) disable iff (!arst_n)
      take && loop_select == plear_pkg::LOOP_REMOTE
      |=> remote_loop_tx_valid && remote_loop_tx_nib == $past(rx_in_nib);
  endproperty
  a_remote: assert property (p_remote)
    else $error("remote loop lost nibble");
  property p_dead;
    @(posedge clk) disable iff (!arst_n)
      take && dead && !pop |=> cnt_q == $past(cnt_q);
  endproperty
  a_dead: assert property (p_dead)
    else $error("word queued during dead time");
  property p_loop_rst;
    @(posedge clk) disable iff (!arst_n)
      $rose(strap_done_q) |-> loop_select == plear_pkg::LOOP_NORMAL;
  endproperty
  a_loop_rst: assert property (p_loop_rst)
    else $error("loop select not normal after reset");
  property p_strap;
    @(posedge clk) disable iff (!arst_n)
      !strap_done_q |=> addr_q == $past(station_address_straps);
  endproperty
  a_strap: assert property (p_strap)
    else $error("address straps not latched");
  c_xcvr: cover property (@(posedge clk) $rose(xcvr_loop_en));
  c_full: cover property (@(posedge clk) cnt_q == 2'h2);
  c_early: cover property (@(posedge clk) take && early_end);

endmodule : plear_top

//--- plear_pkg.sv
// Shared constants and carrier types for the loopback/error/address bank.
// Assumes a single 25 MHz clock and a management port that delivers
// register index, write data and strobes synchronous to that clock.
package plear_pkg;

  // ***********************************************************
  // Register indices and field positions
  // ***********************************************************
  localparam logic [4:0] IDX_LOOP_ERR   = 5'h18;
  localparam logic [4:0] IDX_ADDR_SPEED = 5'h19;
  localparam logic [4:0] IDX_TEN_STATUS = 5'h1B;
  localparam int LOOP_SEL_LSB   = 8;
  localparam int CODE_SEL_BIT   = 4;
  localparam int EARLY_SEL_BIT  = 3;
  localparam int LINK_EN_BIT    = 2;
  localparam int TMO_EN_BIT     = 1;
  localparam int SPEED_BIT      = 6;
  localparam int CONNECT_BIT    = 5;
  localparam int SERIAL_BIT     = 9;
  localparam logic [15:0] LOOP_ERR_RST = 16'h8000;
  localparam logic [15:0] LOOP_ERR_WMASK = 16'h031E;

  // ***********************************************************
  // Loop modes and substituted error codes
  // ***********************************************************
  localparam logic [1:0] LOOP_NORMAL = 2'h0;
  localparam logic [1:0] LOOP_XCVR   = 2'h1;
  localparam logic [1:0] LOOP_REMOTE = 2'h2;
  localparam logic [3:0] CODE_ERR_ALT  = 4'h5;
  localparam logic [3:0] EARLY_ERR_ALT = 4'h4;
  localparam logic [3:0] GENERIC_ERR   = 4'h6;
  localparam logic [3:0] LINK_ERR_CODE = 4'h3;
  localparam logic [3:0] TMO_ERR_CODE  = 4'h2;

  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int CLK_MHZ       = 25;
  localparam int DEAD_US       = 330;
  localparam int DEAD_CYCLES   = DEAD_US * CLK_MHZ;
  localparam int TMO_US        = 722;
  localparam int TMO_CYCLES    = TMO_US * CLK_MHZ;

  // Receive nibble with its error flag and symbol-class marks
  typedef struct packed {
    logic [3:0] nib;
    logic       err;
  } plear_rx_t;

  typedef struct packed {
    logic code_err;
    logic idle;
    logic end_delim;
    logic link_err;
    logic frame_start;
    logic frame_end;
  } plear_sym_t;

endpackage : plear_pkg

//--- plear_mac_model.sv
// MAC-side sink for the receive nibble stream of the register bank.
// Assumes the bench sets stall and reads the captured word queue.
module plear_mac_model (
  // Clock
  input  wire logic                 clk,
  // Stream from the block
  input  wire logic                 rx_out_valid,
  input  wire plear_pkg::plear_rx_t rx_out,
  output logic                      rx_out_ready,
  // Bench control
  input  wire logic                 stall
);
  timeunit 1ns;
  timeprecision 1ps;
  plear_pkg::plear_rx_t got[$];
  // Take a word only at an edge where both sides agree
  always @(posedge clk) begin
    if (rx_out_valid === 1'b1 && rx_out_ready) begin
      got.push_back(rx_out);
    end
  end
  // Ready moves just after an edge, so a stall never splits a word
  always @(negedge clk) begin
    rx_out_ready <= !stall;
  end
  initial rx_out_ready = 1'b0;
endmodule : plear_mac_model

//--- test_plear_top.sv
// Self-checking bench for the loopback, error and address register bank.
// Assumes plear_pkg, plear_top and plear_mac_model are compiled first.
module test_plear_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ***********************************************************
  // Stimulus signals
  // ***********************************************************
  localparam logic [5:0] S_CODE  = 6'h20;
  localparam logic [5:0] S_IDLE  = 6'h10;
  localparam logic [5:0] S_END   = 6'h08;
  localparam logic [5:0] S_LINK  = 6'h04;
  localparam logic [5:0] S_START = 6'h02;
  localparam logic [5:0] S_FEND  = 6'h01;
  logic                  clk = 1'b0;
  logic                  arst_n = 1'b0;
  logic [4:0]            straps = 5'h15;
  logic                  ser_strap = 1'b1;
  logic                  speed_is_10 = 1'b1;
  logic                  link_connected = 1'b1;
  logic                  led_sel = 1'b0;
  logic                  tx_activity = 1'b0;
  logic [4:0]            mgmt_addr = 5'h00;
  logic                  mgmt_wr = 1'b0;
  logic                  mgmt_rd = 1'b0;
  logic [15:0]           mgmt_wdata = 16'h0000;
  logic [15:0]           mgmt_rdata;
  logic                  mgmt_rvalid;
  logic                  rx_in_valid = 1'b0;
  logic                  rx_in_ready;
  logic [3:0]            rx_in_nib = 4'h0;
  plear_pkg::plear_sym_t rx_in_sym = '0;
  logic                  rx_out_valid;
  logic                  rx_out_ready;
  plear_pkg::plear_rx_t  rx_out;
  logic                  lp_valid;
  logic [3:0]            lp_nib_out;
  logic                  xcvr_loop_en;
  logic                  isolate_set;
  logic                  serial_mode_active;
  logic                  led_pin;
  logic                  stall = 1'b0;
  logic [3:0]            lp_nib = 4'h0;
  int                    lp_seen = 0;
  int                    failures = 0;
  int                    checks = 0;

  always #20 clk = ~clk;

  // Short dead time and timeout keep the run brief
  plear_top #(.DEAD_CYC(20), .TMO_CYC(50)) dut_u (
    .clk(clk), .arst_n(arst_n), .station_address_straps(straps),
    .ten_mb_serial_strap(ser_strap), .speed_is_10(speed_is_10),
    .link_connected(link_connected), .activity_led_source_select(led_sel),
    .tx_activity(tx_activity), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
    .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .rx_in_valid(rx_in_valid),
    .rx_in_ready(rx_in_ready), .rx_in_nib(rx_in_nib), .rx_in_sym(rx_in_sym),
    .rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready),
    .rx_out(rx_out), .remote_loop_tx_valid(lp_valid),
    .remote_loop_tx_nib(lp_nib_out), .xcvr_loop_en(xcvr_loop_en),
    .isolate_set(isolate_set), .serial_mode_active(serial_mode_active),
    .activity_led_pin(led_pin));

  plear_mac_model mac_u (
    .clk(clk), .rx_out_valid(rx_out_valid), .rx_out(rx_out),
    .rx_out_ready(rx_out_ready), .stall(stall));

  // Count looped-back pulses; a pulse lasts one cycle only
  always @(posedge clk) begin
    if (lp_valid === 1'b1) begin
      lp_nib <= lp_nib_out;
      lp_seen <= lp_seen + 1;
    end
  end

  // ***********************************************************
  // Shared tasks
  // ***********************************************************
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = 1'b1;
    @(negedge clk);
    mgmt_wr = 1'b0;
    // Strobe stays low a full cycle so a following call never retriggers
    @(negedge clk);
  endtask : wr

  // Read data is taken at the first settled point where rvalid shows
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    @(negedge clk);
    mgmt_rd = 1'b0;
    d = 'x;
    for (int k = 0; k < 4; k++) begin
      if (mgmt_rvalid === 1'b1) begin
        d = mgmt_rdata;
        break;
      end
      @(negedge clk);
    end
    @(negedge clk);
  endtask : rd

  task automatic rd_check(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    check("register read", d, exp);
  endtask : rd_check

  // Leaves valid high so back-to-back words need no gap
  task automatic send(input logic [3:0] n, input logic [5:0] s);
    rx_in_valid = 1'b1;
    rx_in_nib = n;
    rx_in_sym = plear_pkg::plear_sym_t'(s);
    for (int k = 0; k < 40 && rx_in_ready !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
  endtask : send

  function automatic logic [4:0] first_err();
    foreach (mac_u.got[i]) begin
      if (mac_u.got[i].err === 1'b1) return {1'b1, mac_u.got[i].nib};
    end
    return 5'h00;
  endfunction : first_err

  task automatic err_frame(input logic [15:0] ctl, input logic [5:0] s1,
                           input logic [5:0] s2, input logic [4:0] exp);
    wr(plear_pkg::IDX_LOOP_ERR, ctl);
    mac_u.got.delete();
    send(4'h1, S_START);
    send(4'h7, s1);
    send(4'h8, s2);
    send(4'h9, S_END | S_FEND);
    rx_in_valid = 1'b0;
    cyc(8);
    check("error word", 16'(first_err()), 16'(exp));
  endtask : err_frame

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task automatic t_registers();
    rd_check(plear_pkg::IDX_LOOP_ERR, 16'h8000);
    rd_check(plear_pkg::IDX_ADDR_SPEED, 16'h0075);
    rd_check(plear_pkg::IDX_TEN_STATUS, 16'h0200);
    check("isolate", 16'(isolate_set), 16'h0000);
    wr(plear_pkg::IDX_LOOP_ERR, 16'h8012);
    rd_check(plear_pkg::IDX_LOOP_ERR, 16'h8012);
    wr(plear_pkg::IDX_TEN_STATUS, 16'h0000);
    rd_check(plear_pkg::IDX_TEN_STATUS, 16'h0000);
    wr(plear_pkg::IDX_ADDR_SPEED, 16'h0000);
    rd_check(plear_pkg::IDX_ADDR_SPEED, 16'h0060);
    check("isolate", 16'(isolate_set), 16'h0001);
    wr(plear_pkg::IDX_ADDR_SPEED, 16'h0015);
    wr(plear_pkg::IDX_TEN_STATUS, 16'h0200);
    cyc(2);
    check("isolate", 16'(isolate_set), 16'h0000);
  endtask : t_registers

  task automatic t_errors();
    err_frame(16'h8000, S_CODE, 6'h00, 5'h16);
    err_frame(16'h8010, S_CODE, 6'h00, 5'h15);
    err_frame(16'h8000, S_IDLE, S_IDLE, 5'h16);
    err_frame(16'h8008, S_IDLE, S_IDLE, 5'h14);
    err_frame(16'h8004, S_LINK, 6'h00, 5'h13);
    err_frame(16'h8000, S_LINK, 6'h00, 5'h00);
    wr(plear_pkg::IDX_LOOP_ERR, 16'h8002);
    mac_u.got.delete();
    send(4'h1, S_START);
    rx_in_valid = 1'b0;
    cyc(60);
    send(4'h7, S_END | S_FEND);
    rx_in_valid = 1'b0;
    cyc(8);
    check("timeout word", 16'(first_err()), 16'h0012);
  endtask : t_errors

  task automatic t_loops();
    int base;
    wr(plear_pkg::IDX_LOOP_ERR, 16'h8100);
    mac_u.got.delete();
    send(4'h1, S_START);
    send(4'h2, S_END | S_FEND);
    rx_in_valid = 1'b0;
    cyc(6);
    check("xcvr loop", 16'(xcvr_loop_en), 16'h0001);
    check("dead words", 16'(mac_u.got.size()), 16'h0000);
    cyc(25);
    send(4'h1, S_START);
    rx_in_valid = 1'b0;
    cyc(8);
    check("after dead", 16'(mac_u.got.size() > 0), 16'h0001);
    wr(plear_pkg::IDX_LOOP_ERR, 16'h8200);
    base = lp_seen;
    send(4'hA, S_START);
    rx_in_valid = 1'b0;
    cyc(6);
    check("loop nibble", {12'(lp_seen > base), lp_nib}, 16'h001A);
    wr(plear_pkg::IDX_LOOP_ERR, 16'h8000);
  endtask : t_loops

  // Receiver stalls until the buffer refuses, then drains it in order
  task automatic t_buffer();
    int n;
    n = 0;
    mac_u.got.delete();
    stall = 1'b1;
    cyc(2);
    rx_in_valid = 1'b1;
    for (int k = 0; k < 6; k++) begin
      rx_in_nib = 4'(n);
      rx_in_sym = plear_pkg::plear_sym_t'((n == 0) ? S_START : 6'h00);
      if (rx_in_ready !== 1'b1) break;
      n++;
      @(negedge clk);
    end
    rx_in_valid = 1'b0;
    check("full refuses", 16'(rx_in_ready), 16'h0000);
    check("depth", 16'(n >= 2 && n <= 3), 16'h0001);
    stall = 1'b0;
    cyc(10);
    check("drained", 16'(mac_u.got.size()), 16'(n));
    check("last word", 16'(mac_u.got[n - 1]), 16'(5'(n - 1) << 1));
  endtask : t_buffer

  task automatic t_pins();
    cyc(2);
    check("serial 10", 16'(serial_mode_active), 16'h0001);
    speed_is_10 = 1'b0;
    cyc(3);
    check("serial 100", 16'(serial_mode_active), 16'h0000);
    rd_check(plear_pkg::IDX_ADDR_SPEED, 16'h0035);
    tx_activity = 1'b1;
    cyc(3);
    check("led activity", 16'(led_pin), 16'h0001);
    tx_activity = 1'b0;
    cyc(3);
    check("led idle", 16'(led_pin), 16'h0000);
    led_sel = 1'b1;
    cyc(3);
    check("led connect", 16'(led_pin), 16'h0001);
    link_connected = 1'b0;
    cyc(3);
    check("led disconnect", 16'(led_pin), 16'h0000);
    rd_check(plear_pkg::IDX_ADDR_SPEED, 16'h0015);
  endtask : t_pins

  // Watchdog sized well past the few hundred cycles the scenarios need
  initial begin
    #240000;
    failures++;
    end_of_test();
  end

  initial begin
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    cyc(2);
    t_registers();
    t_errors();
    t_loops();
    t_buffer();
    t_pins();
    end_of_test();
  end
endmodule : test_plear_top
